// ===== verilog/sys_clock_ctrl.sv
// Purpose: system clock selection, monitor, pll and bus prescalers
// Assumes: source clocks are sampled pins, slower than half of clock_in
// Notes:   system and bus clocks downstream are single-cycle enables on clock_in; i2s mclk is a toggled level
//
// Summary of operation
// [R01] reset selects internal 16 MHz rc oscillator as core clock
// [R02] software selects rc or 4-26 MHz external source
// [R03] monitor detects external source that stops toggling
// [R04] on failure fall back to rc, raise interrupt if enabled
// [R05] chosen source feeds main pll, system clock at most 100 MHz
// [R06] pll input failure reported through interrupt
// [R07] separate prescalers for ahb, apb2 and apb1 domains
// [R08] ahb and apb2 clocks never above 100 MHz
// [R09] apb1 clock never above 50 MHz
// [R10] audio pll drives i2s master clock, 8 to 192 kHz rates
// [R11] every source switch is glitch-free
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module sys_clock_ctrl
   import clk_ctrl_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        rc_clk_in,
   input  wire logic        ext_clk_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   output logic             sys_tick_out,
   output logic             ahb_tick_out,
   output logic             apb2_tick_out,
   output logic             apb1_tick_out,
   output logic             i2s_mclk_out,
   output logic             irq_out
);
   // two-stage synchronisers for source pins
   logic [1:0] rc_sync_q;
   logic [1:0] ext_sync_q;
   logic       rc_last_q;
   logic       ext_last_q;
   logic       rc_tick;
   logic       ext_tick;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rc_sync_q  <= 2'b00;
         ext_sync_q <= 2'b00;
         rc_last_q  <= 1'b0;
         ext_last_q <= 1'b0;
      end else begin
         rc_sync_q  <= {rc_sync_q[0], rc_clk_in};
         ext_sync_q <= {ext_sync_q[0], ext_clk_in};
         rc_last_q  <= rc_sync_q[1];
         ext_last_q <= ext_sync_q[1];
      end
   end

   assign rc_tick  = rc_sync_q[1] && !rc_last_q;
   assign ext_tick = ext_sync_q[1] && !ext_last_q;

   // registers
   logic [1:0]  src_sel_q;
   logic        ext_en_q;
   logic        mon_en_q;
   logic        irq_en_q;
   logic        pll_en_q;
   logic        pll_src_ext_q;
   logic        aud_en_q;
   pll_cfg_t    pll_cfg_q;
   presc_t      presc_q;
   logic [7:0]  aud_mul_q;
   logic [7:0]  aud_div_q;
   logic        fail_q;
   logic        pll_fail_q;

   logic        wr_ctrl;
   logic        wr_pll;
   logic        wr_presc;
   logic        wr_audio;
   logic        wr_clear;

   assign wr_ctrl  = wr_in && (addr_in == ADDR_CTRL);
   assign wr_pll   = wr_in && (addr_in == ADDR_PLL);
   assign wr_presc = wr_in && (addr_in == ADDR_PRESC);
   assign wr_audio = wr_in && (addr_in == ADDR_AUDIO);
   assign wr_clear = wr_in && (addr_in == ADDR_CLEAR);

   // clock monitor on external source
   logic [7:0] gap_q;
   logic       mon_trip;
   logic       ext_used;

   assign ext_used = ext_en_q && mon_en_q &&
                     ((src_sel_q == SRC_EXT) ||
                      (src_sel_q == SRC_PLL && pll_src_ext_q));
   assign mon_trip = ext_used && (gap_q >= MON_GAP_CYC_8); // [R03]

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) gap_q <= 8'h00;
      else if (ext_tick || !ext_used) gap_q <= 8'h00;
      else if (!mon_trip) gap_q <= gap_q + 8'h01;
   end

   // failure flags: set wins over clear
   logic fail_d;
   logic pll_fail_d;
   logic new_fail;

   assign new_fail   = mon_trip && !fail_q;
   assign fail_d     = new_fail || (fail_q && !(wr_clear && wdata_in[0]));
   assign pll_fail_d = (new_fail && src_sel_q == SRC_PLL) ||
                       (pll_fail_q && !(wr_clear && wdata_in[1])); // [R06]

   // control register writes; failure forces rc
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         src_sel_q     <= SRC_RC;                              // [R01]
         ext_en_q      <= 1'b0;
         mon_en_q      <= 1'b0;
         irq_en_q      <= 1'b0;
         pll_en_q      <= 1'b0;
         pll_src_ext_q <= 1'b0;
         aud_en_q      <= 1'b0;
      end else if (new_fail) begin
         src_sel_q <= SRC_RC;                                  // [R04]
         pll_en_q  <= 1'b0;
      end else if (wr_ctrl) begin
         src_sel_q     <= (wdata_in[1:0] == 2'h3) ? SRC_RC
                                                   : wdata_in[1:0]; // [R02]
         ext_en_q      <= wdata_in[2];
         mon_en_q      <= wdata_in[3];
         irq_en_q      <= wdata_in[4];
         pll_en_q      <= wdata_in[5];
         pll_src_ext_q <= wdata_in[6];
         aud_en_q      <= wdata_in[7];
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pll_cfg_q  <= '{mul: PLL_MUL_RST, div: PLL_DIV_RST};
         presc_q    <= '{ahb: AHB_DIV_RST, apb2: APB2_DIV_RST,
                         apb1: APB1_DIV_RST};
         aud_mul_q  <= AUD_MUL_RST;
         aud_div_q  <= AUD_DIV_RST;
         fail_q     <= 1'b0;
         pll_fail_q <= 1'b0;
      end else begin
         if (wr_pll) pll_cfg_q <= pll_cfg_t'(wdata_in[11:0]);
         if (wr_presc) presc_q <= presc_t'(wdata_in[11:0]);   // [R07]
         if (wr_audio) begin
            aud_mul_q <= wdata_in[7:0];
            aud_div_q <= wdata_in[15:8];
         end
         fail_q     <= fail_d;
         pll_fail_q <= pll_fail_d;
      end
   end

   // main pll model: fractional accumulator of source ticks
   logic       pll_ref_tick;
   logic [8:0] pll_acc_q;
   logic [8:0] pll_sum;
   logic       pll_tick;
   logic [8:0] pll_lim;

   assign pll_ref_tick = pll_src_ext_q ? ext_tick : rc_tick;
   assign pll_lim  = {1'b0, pll_cfg_q.div, 4'h0};
   assign pll_sum  = pll_acc_q + (pll_ref_tick ? {1'b0, pll_cfg_q.mul}
                                               : 9'h000);
   assign pll_tick = pll_en_q && (pll_acc_q >= pll_lim)    // [R05]
                     && (pll_lim != 9'h000);

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) pll_acc_q <= 9'h000;
      else if (!pll_en_q) pll_acc_q <= 9'h000;
      else if (pll_tick) pll_acc_q <= 9'(pll_sum - pll_lim);
      else pll_acc_q <= pll_sum;
   end

   // glitch-free selection: rc/ext first, then that against pll
   logic base_tick;
   logic sys_tick;
   logic want_ext;
   logic want_pll;

   assign want_ext = (src_sel_q == SRC_EXT) && ext_en_q;
   assign want_pll = (src_sel_q == SRC_PLL) && pll_en_q;

   clk_glitch_mux u_mux_base (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .sel_b_in  (want_ext),
      .tick_a_in (rc_tick),
      .tick_b_in (ext_tick),
      .tick_out  (base_tick),
      .on_b_out  ()
   );                                                          // [R11]

   clk_glitch_mux u_mux_pll (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .sel_b_in  (want_pll),
      .tick_a_in (base_tick),
      .tick_b_in (pll_tick),
      .tick_out  (sys_tick),
      .on_b_out  ()
   );                                                          // [R11]

   // prescalers; minimum codes cap the domain rates
   logic ahb_tick;
   logic apb2_tick;
   logic apb1_tick;

   clk_divider #(.MIN_CODE(4'h0)) u_ahb (
      .clock_in    (clock_in),
      .resetn_in   (resetn_in),
      .code_in     (presc_q.ahb),
      .src_tick_in (sys_tick),
      .tick_out    (ahb_tick)
   );                                                          // [R08]

   clk_divider #(.MIN_CODE(4'h0)) u_apb2 (
      .clock_in    (clock_in),
      .resetn_in   (resetn_in),
      .code_in     (presc_q.apb2),
      .src_tick_in (sys_tick),
      .tick_out    (apb2_tick)
   );                                                          // [R08]

   clk_divider #(.MIN_CODE(4'h1)) u_apb1 (
      .clock_in    (clock_in),
      .resetn_in   (resetn_in),
      .code_in     (presc_q.apb1),
      .src_tick_in (sys_tick),
      .tick_out    (apb1_tick)
   );                                                          // [R09]

   // audio pll: fractional divider from control clock to mclk
   logic [15:0] aud_acc_q;
   logic [15:0] aud_lim;
   logic        aud_wrap;

   assign aud_lim  = {aud_div_q, 8'h00};
   assign aud_wrap = (aud_acc_q + {8'h00, aud_mul_q}) >= aud_lim;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aud_acc_q    <= 16'h0000;
         i2s_mclk_out <= 1'b0;
      end else if (!aud_en_q || aud_lim == 16'h0000) begin
         aud_acc_q    <= 16'h0000;
         i2s_mclk_out <= 1'b0;
      end else if (aud_wrap) begin
         aud_acc_q    <= 16'(aud_acc_q + {8'h00, aud_mul_q} - aud_lim);
         i2s_mclk_out <= !i2s_mclk_out;                       // [R10]
      end else begin
         aud_acc_q    <= aud_acc_q + {8'h00, aud_mul_q};
      end
   end

   // read port and outputs
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   assign status_word = {26'h0, pll_en_q, ext_en_q, src_sel_q,
                         pll_fail_q, fail_q};
   assign rd_mux =
      (addr_in == ADDR_CTRL)   ? {24'h0, aud_en_q, pll_src_ext_q, pll_en_q,
                                  irq_en_q, mon_en_q, ext_en_q, src_sel_q} :
      (addr_in == ADDR_PLL)    ? {20'h0, pll_cfg_q} :
      (addr_in == ADDR_PRESC)  ? {20'h0, presc_q} :
      (addr_in == ADDR_AUDIO)  ? {16'h0, aud_div_q, aud_mul_q} :
      (addr_in == ADDR_STATUS) ? status_word : 32'h0000_0000;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out     <= 32'h0000_0000;
         sys_tick_out  <= 1'b0;
         ahb_tick_out  <= 1'b0;
         apb2_tick_out <= 1'b0;
         apb1_tick_out <= 1'b0;
         irq_out       <= 1'b0;
      end else begin
         rdata_out     <= rd_in ? rd_mux : 32'h0000_0000;
         sys_tick_out  <= sys_tick;
         ahb_tick_out  <= ahb_tick;
         apb2_tick_out <= apb2_tick;
         apb1_tick_out <= apb1_tick;
         irq_out       <= irq_en_q && (fail_q || pll_fail_q); // [R04]
      end
   end
endmodule : sys_clock_ctrl

// ===== verilog/clk_ctrl_pkg.sv
// Purpose: shared constants and types for the system clock controller
// Assumes: 100 MHz control clock, 32-bit register port
// Notes:   clock sources arrive as sampled levels
package clk_ctrl_pkg;

   localparam int          CLK_MHZ         = 100;
   localparam int          RC_MHZ          = 16;
   localparam int          EXT_MIN_MHZ     = 4;
   localparam int          EXT_MAX_MHZ     = 26;
   localparam int          SYS_MAX_MHZ     = 100;
   localparam int          APB_LS_MAX_MHZ  = 50;
   localparam int          AUDIO_MIN_KHZ   = 8;
   localparam int          AUDIO_MAX_KHZ   = 192;

   // monitor: longest gap between source edges, in control cycles
   localparam int          MON_GAP_NS      = 1000;
   localparam int          MON_GAP_CYC     = MON_GAP_NS * CLK_MHZ / 1000;
   localparam logic [7:0]  MON_GAP_CYC_8   = 8'(MON_GAP_CYC);

   localparam logic [3:0]  ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  ADDR_PLL        = 4'h1;
   localparam logic [3:0]  ADDR_PRESC      = 4'h2;
   localparam logic [3:0]  ADDR_AUDIO      = 4'h3;
   localparam logic [3:0]  ADDR_STATUS     = 4'h4;
   localparam logic [3:0]  ADDR_CLEAR      = 4'h5;

   localparam logic [1:0]  SRC_RC          = 2'h0;
   localparam logic [1:0]  SRC_EXT         = 2'h1;
   localparam logic [1:0]  SRC_PLL         = 2'h2;

   // reset values of the pll, prescaler and audio registers
   localparam logic [7:0]  PLL_MUL_RST     = 8'h06;
   localparam logic [3:0]  PLL_DIV_RST     = 4'h1;
   localparam logic [3:0]  AHB_DIV_RST     = 4'h0;
   localparam logic [3:0]  APB2_DIV_RST    = 4'h0;
   localparam logic [3:0]  APB1_DIV_RST    = 4'h1;
   localparam logic [7:0]  AUD_MUL_RST     = 8'h30;
   localparam logic [7:0]  AUD_DIV_RST     = 8'h7D;

   typedef struct packed {
      logic [7:0] mul;
      logic [3:0] div;
   } pll_cfg_t;

   typedef struct packed {
      logic [3:0] ahb;
      logic [3:0] apb2;
      logic [3:0] apb1;
   } presc_t;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_OFF  = 2'b01,
      SW_ON   = 2'b10
   } sw_state_t;

endpackage : clk_ctrl_pkg

// ===== verilog/clk_divider.sv
// Purpose: divide-by-(2^n) enable generator for one bus domain
// Assumes: div code n gives period 2^n source ticks
// Notes:   code below MIN_CODE is raised to MIN_CODE
`timescale 1ns/10ps
module clk_divider
   import clk_ctrl_pkg::*;
#(
   parameter logic [3:0] MIN_CODE = 4'h0
) (
   input  wire logic       clock_in,
   input  wire logic       resetn_in,
   input  wire logic [3:0] code_in,
   input  wire logic       src_tick_in,
   output logic            tick_out
);
   logic [3:0]  eff_code;
   logic [15:0] cnt_q;
   logic [15:0] mask;
   logic        hit;

   assign eff_code = (code_in < MIN_CODE) ? MIN_CODE : code_in;
   assign mask     = 16'((17'h1 << eff_code) - 17'h1);
   assign hit      = src_tick_in && ((cnt_q & mask) == 16'h0000);

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q    <= 16'h0000;
         tick_out <= 1'b0;
      end else begin
         if (src_tick_in) cnt_q <= cnt_q + 16'h0001;
         tick_out <= hit;
      end
   end
endmodule : clk_divider

// ===== verilog/clk_glitch_mux.sv
// Purpose: glitch-free two-way enable selector
// Assumes: both inputs are single-cycle tick enables on clock_in
// Notes:   old source is stopped on its own tick, or once stalled, before new one starts
`timescale 1ns/10ps
module clk_glitch_mux
   import clk_ctrl_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic resetn_in,
   input  wire logic sel_b_in,
   input  wire logic tick_a_in,
   input  wire logic tick_b_in,
   output logic      tick_out,
   output logic      on_b_out
);
   sw_state_t state_q;
   sw_state_t state_d;
   logic      cur_b_q;
   logic      gate_q;
   logic      cur_tick;
   logic [7:0] quiet_q;
   logic      stalled;

   assign cur_tick = cur_b_q ? tick_b_in : tick_a_in;
   // a dead source never ticks again: leave it once it is quiet long enough
   assign stalled  = (quiet_q >= MON_GAP_CYC_8);

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) quiet_q <= 8'h00;
      else if (cur_tick) quiet_q <= 8'h00;
      else if (!stalled) quiet_q <= quiet_q + 8'h01;
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         SW_IDLE: if (sel_b_in != cur_b_q && (cur_tick || stalled)) begin
            state_d = SW_OFF;
         end
         SW_OFF:  state_d = SW_ON;
         SW_ON: begin
            if ((cur_b_q ? tick_b_in : tick_a_in)) state_d = SW_IDLE;
         end
         default: state_d = SW_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q  <= SW_IDLE;
         cur_b_q  <= 1'b0;
         gate_q   <= 1'b1;
         tick_out <= 1'b0;
         on_b_out <= 1'b0;
      end else begin
         state_q  <= state_d;
         if (state_q == SW_IDLE && state_d == SW_OFF) gate_q <= 1'b0;
         if (state_q == SW_OFF) cur_b_q <= sel_b_in;
         if (state_q == SW_ON && state_d == SW_IDLE) gate_q <= 1'b1;
         tick_out <= gate_q && cur_tick;
         on_b_out <= cur_b_q;
      end
   end
endmodule : clk_glitch_mux

// ===== bench/sys_clock_ctrl_assertions.sv
// Purpose: port checks for the system clock controller
// Assumes: control word shadowed here from register writes
// Notes:   bound into every sys_clock_ctrl instance
`timescale 1ns/10ps
module sys_clock_ctrl_assertions
   import clk_ctrl_pkg::*;
(
   input wire logic        clock_in,
   input wire logic        resetn_in,
   input wire logic        rc_clk_in,
   input wire logic        ext_clk_in,
   input wire logic [3:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        sys_tick_out,
   input wire logic        ahb_tick_out,
   input wire logic        apb2_tick_out,
   input wire logic        apb1_tick_out,
   input wire logic        i2s_mclk_out,
   input wire logic        irq_out
);
   logic [7:0] ctrl_q;
   logic [6:0] quiet_q;
   logic [7:0] gap_q;
   logic       rc_prev_q;
   logic       ext_prev_q;
   wire logic       ctrl_wr  = wr_in && (addr_in == ADDR_CTRL);
   wire logic       rc_rise  = rc_clk_in && !rc_prev_q;
   wire logic       ext_rise = ext_clk_in && !ext_prev_q;
   wire logic       settled  = quiet_q[6];
   wire logic [1:0] src_sh   = ctrl_q[1:0];
   wire logic       armed    = (src_sh == SRC_EXT) && (ctrl_q[4:2] == 3'h7);

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ctrl_q <= 8'h00;
         quiet_q <= 7'h00;
         gap_q <= 8'h00;
         rc_prev_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         rc_prev_q <= rc_clk_in;
         ext_prev_q <= ext_clk_in;
         if (ctrl_wr) ctrl_q <= wdata_in[7:0];
         quiet_q <= ctrl_wr ? 7'h00 : (settled ? quiet_q : quiet_q + 7'h01);
         if (ext_clk_in != ext_prev_q) gap_q <= 8'h00;
         else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   rst_quiet_a: assert property ($rose(resetn_in) |-> rdata_out == 32'h0
      && !(sys_tick_out || ahb_tick_out || apb2_tick_out || apb1_tick_out
      || i2s_mclk_out || irq_out)) else $error("outputs busy after reset");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data without a read");
   rc_follow_a: assert property (rc_rise && src_sh == SRC_RC && settled
      |-> ##[3:7] sys_tick_out) else $error("rc edge gave no system tick");
   ext_follow_a: assert property (ext_rise && src_sh == SRC_EXT && settled
      |-> ##[3:7] sys_tick_out) else $error("ext edge gave no system tick");
   sys_space_a: assert property (sys_tick_out && src_sh != SRC_PLL
      && settled |=> !sys_tick_out [*4]) else $error("short system tick gap");
   ahb_space_a: assert property (ahb_tick_out && src_sh != SRC_PLL
      && settled |=> !ahb_tick_out [*4]) else $error("short ahb tick gap");
   apb2_space_a: assert property (apb2_tick_out && src_sh != SRC_PLL
      && settled |=> !apb2_tick_out [*4]) else $error("short apb2 tick gap");
   apb1_half_a: assert property (apb1_tick_out |=> !apb1_tick_out)
      else $error("apb1 tick in two cycles");
   irq_mask_a: assert property ((!ctrl_q[4] && !$past(ctrl_q[4]))
      |-> !irq_out) else $error("masked interrupt raised");
   fail_irq_a: assert property (gap_q == 8'd120 && armed && settled
      |-> ##[0:60] irq_out) else $error("stopped source not flagged");
endmodule : sys_clock_ctrl_assertions

bind sys_clock_ctrl sys_clock_ctrl_assertions chk (
   .clock_in(clock_in), .resetn_in(resetn_in), .rc_clk_in(rc_clk_in),
   .ext_clk_in(ext_clk_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .sys_tick_out(sys_tick_out), .ahb_tick_out(ahb_tick_out),
   .apb2_tick_out(apb2_tick_out), .apb1_tick_out(apb1_tick_out),
   .i2s_mclk_out(i2s_mclk_out), .irq_out(irq_out));

// ===== bench/osc_model.sv
// Purpose: rc oscillator and external clock source
// Assumes: external source runs at 8 MHz, or 4 MHz when slow
// Notes:   a stopped source holds its pin, as a dead crystal would
`timescale 1ns/10ps
module osc_model (
   input  wire logic ext_run_in,
   input  wire logic ext_slow_in,
   output logic      rc_clk_out,
   output logic      ext_clk_out
);
   initial begin
      rc_clk_out = 1'b0;
      forever #31.25 rc_clk_out = ~rc_clk_out;
   end
   initial begin
      ext_clk_out = 1'b0;
      #3.7;
      forever begin
         if (ext_run_in) ext_clk_out = ~ext_clk_out;
         if (ext_slow_in) #125; else #62.5;
      end
   end
endmodule : osc_model

// ===== bench/tb_system_clock_controller.sv
// Purpose: self-checking bench for the system clock controller
// Assumes: rc at 16 MHz, external source from osc_model
// Notes:   reads are scored against a queue of expected words
`timescale 1ns/10ps
module tb_system_clock_controller
   import clk_ctrl_pkg::*;
;
   logic        clock_in, resetn_in, rc_clk, ext_clk, ext_run, ext_slow;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, r, p;
   logic        wr, rd, rd_seen, sys_t, ahb_t, apb2_t, apb1_t, mclk, irq;
   logic [31:0] exp_q[$];
   int          err_count, total_checks, seed, i, k;
   int          n_sys, n_ahb, n_apb2, n_apb1, n_mclk;

   osc_model osc (.ext_run_in(ext_run), .ext_slow_in(ext_slow),
                  .rc_clk_out(rc_clk), .ext_clk_out(ext_clk));
   sys_clock_ctrl dut (.clock_in(clock_in), .resetn_in(resetn_in),
      .rc_clk_in(rc_clk), .ext_clk_in(ext_clk), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .sys_tick_out(sys_t), .ahb_tick_out(ahb_t), .apb2_tick_out(apb2_t),
      .apb1_tick_out(apb1_t), .i2s_mclk_out(mclk), .irq_out(irq));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   task automatic end_of_test;
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic check_near(input int got, input int want);
      check({31'h0, got >= want - 2 && got <= want + 2}, 32'h1);
   endtask : check_near

   always @(posedge clock_in) begin
      rd_seen <= rd;
      if (rd_seen === 1'b1) check(rdata, exp_q.pop_front());
   end

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
      @(posedge clock_in);
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      @(posedge clock_in);
   endtask : rd_reg

   task automatic do_reset;
      resetn_in <= 1'b0;
      repeat (20) @(posedge clock_in);
      resetn_in <= 1'b1;
      @(posedge clock_in);
   endtask : do_reset

   task automatic count_ticks(input int n);
      logic last;
      n_sys = 0;
      n_ahb = 0;
      n_apb2 = 0;
      n_apb1 = 0;
      n_mclk = 0;
      last = mclk;
      repeat (n) begin
         @(posedge clock_in);
         #1;
         n_sys += int'(sys_t);
         n_ahb += int'(ahb_t);
         n_apb2 += int'(apb2_t);
         n_apb1 += int'(apb1_t);
         n_mclk += int'(mclk !== last);
         last = mclk;
      end
   endtask : count_ticks

   task automatic wait_irq;
      for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clock_in);
      if (i == 400) begin
         err_count++;
         end_of_test();
      end
   endtask : wait_irq

   initial begin
      seed = 30836;
      err_count = 0;
      total_checks = 0;
      {addr, wdata, wr, rd, rd_seen, ext_slow} = '0;
      ext_run = 1'b1;
      resetn_in = 1'b0;
      do_reset();
      rd_reg(ADDR_STATUS, 32'h0);
      rd_reg(ADDR_PLL, {20'h0, PLL_MUL_RST, PLL_DIV_RST});
      rd_reg(ADDR_PRESC, {20'h0, AHB_DIV_RST, APB2_DIV_RST, APB1_DIV_RST});
      rd_reg(ADDR_AUDIO, {16'h0, AUD_DIV_RST, AUD_MUL_RST});
      wr_reg(4'hF, 32'hFFFFFFFF);
      rd_reg(4'hF, 32'h0);
      for (k = 0; k < 3; k++) begin
         r = $random(seed);
         p = {20'h0, 4'(r[1:0]), 4'(r[3:2]), 4'(1 + r[4])};
         wr_reg(ADDR_PRESC, p);
         rd_reg(ADDR_PRESC, p);
         count_ticks(1000);
         check_near(n_sys, 160);
         check_near(n_ahb, 160 >> r[1:0]);
         check_near(n_apb2, 160 >> r[3:2]);
         check_near(n_apb1, 160 >> (1 + r[4]));
      end
      // external source, fast then slow, then it dies
      wr_reg(ADDR_CTRL, 32'h1D);
      rd_reg(ADDR_STATUS, 32'h14);
      repeat (100) @(posedge clock_in);
      count_ticks(1000);
      check_near(n_sys, 80);
      ext_slow <= 1'b1;
      repeat (50) @(posedge clock_in);
      count_ticks(1000);
      check_near(n_sys, 40);
      ext_run <= 1'b0;
      wait_irq();
      rd_reg(ADDR_STATUS, 32'h11);
      count_ticks(1000);
      check_near(n_sys, 160);
      wr_reg(ADDR_CTRL, 32'h10);
      wr_reg(ADDR_CLEAR, 32'h1);
      repeat (3) @(posedge clock_in);
      check({31'h0, irq}, 32'h0);
      rd_reg(ADDR_STATUS, 32'h0);
      // failure with the interrupt masked
      ext_run <= 1'b1;
      ext_slow <= 1'b0;
      repeat (50) @(posedge clock_in);
      wr_reg(ADDR_CTRL, 32'h0D);
      repeat (50) @(posedge clock_in);
      ext_run <= 1'b0;
      repeat (200) @(posedge clock_in);
      check({31'h0, irq}, 32'h0);
      rd_reg(ADDR_STATUS, 32'h11);
      wr_reg(ADDR_CTRL, 32'h0);
      wr_reg(ADDR_CLEAR, 32'h1);
      // pll fed by the external source, which then fails
      ext_run <= 1'b1;
      repeat (50) @(posedge clock_in);
      wr_reg(ADDR_CTRL, 32'h7E);
      repeat (200) @(posedge clock_in);
      rd_reg(ADDR_STATUS, 32'h38);
      count_ticks(500);
      check({31'h0, n_sys > 0}, 32'h1);
      ext_run <= 1'b0;
      wait_irq();
      rd_reg(ADDR_STATUS, 32'h13);
      wr_reg(ADDR_CTRL, 32'h10);
      wr_reg(ADDR_CLEAR, 32'h3);
      rd_reg(ADDR_STATUS, 32'h0);
      // audio pll
      r = $random(seed);
      wr_reg(ADDR_AUDIO, {16'h0, r[15:0]});
      rd_reg(ADDR_AUDIO, {16'h0, r[15:0]});
      wr_reg(ADDR_AUDIO, {16'h0, AUD_DIV_RST, AUD_MUL_RST});
      wr_reg(ADDR_CTRL, 32'h80);
      count_ticks(2000);
      check({31'h0, n_mclk > 0}, 32'h1);
      // reset in mid-run returns to the rc source
      ext_run <= 1'b1;
      wr_reg(ADDR_CTRL, 32'h1D);
      repeat (100) @(posedge clock_in);
      do_reset();
      rd_reg(ADDR_STATUS, 32'h0);
      repeat (100) @(posedge clock_in);
      count_ticks(1000);
      check_near(n_sys, 160);
      end_of_test();
   end
endmodule : tb_system_clock_controller
